/* rtl/spcs_pkg.sv */
// Purpose: Shared constants for the serial clock synthesizer model.
// Assumes: A 40 MHz system clock and 32-bit APB data.
// Notes: Offsets are byte addresses of aligned 32-bit words.
package spcs_pkg;

   // ------------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------------
   localparam int CLK_KHZ = 40_000;
   localparam int CLK_PERIOD_NS = 25;
   localparam int GLIDE_TIME_NS = 1_000_000;
   localparam int GLIDE_STEPS = 256;
   localparam int GLIDE_TICK_CYCLES =
      GLIDE_TIME_NS / (CLK_PERIOD_NS * GLIDE_STEPS);
   localparam int GLIDE_SHIFT = 4;
   localparam int FB_OFFSET = 8;
   localparam int REF_OFFSET = 2;

   // ------------------------------------------------------------------
   // Setting word layout
   // ------------------------------------------------------------------
   localparam int SET_W = 24;
   localparam int CRY_LSB = 22;
   localparam int CRY_W = 2;
   localparam int TRIM_BIT = 21;
   localparam int SEC_LSB = 19;
   localparam int SEC_W = 2;
   localparam int OSEL_LSB = 16;
   localparam int OSEL_W = 3;
   localparam int FB_LSB = 7;
   localparam int FB_W = 9;
   localparam int REFW_LSB = 0;
   localparam int REFW_W = 7;
   localparam logic [23:0] STARTUP_DEFINED = 24'h23_0204;

   // ------------------------------------------------------------------
   // Secondary output sources
   // ------------------------------------------------------------------
   localparam logic [1:0] SEC_REF = 2'h0;
   localparam logic [1:0] SEC_REF_HALF = 2'h1;
   localparam logic [1:0] SEC_LOW = 2'h2;
   localparam logic [1:0] SEC_PRIM_HALF = 2'h3;

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_SETTING = 8'h00;
   localparam logic [7:0] ADDR_SHIFT = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_TUNE = 8'h0C;
   localparam logic [7:0] ADDR_CTRL = 8'h10;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
   localparam logic [31:0] TUNE_MAX = 32'h8000_0000;
   localparam logic [4:0] PIN_RESET = 5'h08;

   // ------------------------------------------------------------------
   // Tuning sequencer states
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      CALC_IDLE = 2'b00,
      CALC_RUN = 2'b01,
      CALC_GLIDE = 2'b10
   } spcs_calc_e;

endpackage

/* rtl/spcs_divider.sv */
// Purpose: Sequential restoring divider for the tuning word.
// Assumes: Denominator is never zero while a division runs.
// Notes: Quotient keeps FW fraction bits; ovf flags a lost top bit.
`timescale 1ns/1ps
module spcs_divider #(
   parameter int NW = 32,
   parameter int DW = 32,
   parameter int FW = 32
) (
   // System
   input wire logic clk,
   input wire logic rst_n,
   // Request
   input wire logic start,
   input wire logic [NW-1:0] num,
   input wire logic [DW-1:0] den,
   // Result
   output logic busy,
   output logic done,
   output logic [FW-1:0] quo,
   output logic ovf
);

   localparam int STEPS = NW + FW;

   logic [7:0] cnt_r;
   logic [NW+FW-1:0] num_r;
   logic [DW-1:0] den_r;
   logic [DW:0] rem_r;
   logic [FW-1:0] quo_r;
   logic ovf_r;
   logic done_r;
   wire logic [DW:0] trial_w = {rem_r[DW-1:0], num_r[NW+FW-1]};
   wire logic ge_w = trial_w >= {1'b0, den_r};
   wire logic last_w = cnt_r == 8'(1);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
         num_r <= '0;
         den_r <= '0;
         rem_r <= '0;
         quo_r <= '0;
         ovf_r <= 1'b0;
         done_r <= 1'b0;
      end else if (start) begin
         cnt_r <= 8'(STEPS);
         num_r <= {num, {FW{1'b0}}};
         den_r <= den;
         rem_r <= '0;
         quo_r <= '0;
         ovf_r <= 1'b0;
         done_r <= 1'b0;
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - 8'(1);
         num_r <= {num_r[NW+FW-2:0], 1'b0};
         rem_r <= ge_w ? trial_w - {1'b0, den_r} : trial_w;
         quo_r <= {quo_r[FW-2:0], ge_w};
         ovf_r <= ovf_r | quo_r[FW-1];
         done_r <= last_w;
      end else begin
         done_r <= 1'b0;
      end
   end

   assign busy = cnt_r != '0;
   assign done = done_r;
   assign quo = quo_r;
   assign ovf = ovf_r;

endmodule

/* rtl/spcs_top.sv */
// Purpose: Setting latch and output clock logic of a serially
//    programmed clock synthesizer, with an APB status port.
// Assumes: 40 MHz CLK; serial pins, reference and power-down pin are
//    asynchronous and pass two flip-flops before use.
// Notes: The oscillator is a phase accumulator, so it only reaches
//    half the CLK rate.
//
// Contract
// - Primary output spans programmed frequency range.
// - New frequency settles within ten milliseconds.
// - Unchanged output divider gives smooth transition.
// - Power-down low tristates both outputs.
// - Undefined variant may start with random settings.
// - Defined variant starts at reference frequency.
// - Primary frequency follows the divider equation.
// - Output select maps to documented divide values.
// - Secondary select routes four secondary sources.
// - Zero reference word bypasses to reference.
// - Bypass entry and exit may glitch.
// - Twenty-four bits shift in most significant first.
// - Load strobe copies shift contents to latch.
// - Divider changes glide over about one millisecond.
// - Latch programmable and kept through power-down.
`timescale 1ns/1ps
module spcs_top #(
   parameter logic [23:0] STARTUP_WORD = spcs_pkg::STARTUP_DEFINED,
   parameter int unsigned REF_KHZ = 10_000
) (
   // System
   input wire logic CLK,
   input wire logic NRST,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [spcs_pkg::ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Serial programming port
   input wire logic SER_CLOCK,
   input wire logic SER_DATA,
   input wire logic SER_LOAD,
   // Reference and power-down
   input wire logic REFERENCE_INPUT,
   input wire logic POWER_DOWN_TRISTATE_N,
   // Output clocks
   output logic PRIMARY_OUT_CLOCK,
   output logic PRIMARY_OUT_OE_N,
   output logic SECONDARY_OUT_CLOCK,
   output logic SECONDARY_OUT_OE_N
);
   import spcs_pkg::*;

   // ------------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------------
   function automatic logic [3:0] output_divide_value(
      input logic [2:0] sel
   );
      case (sel)
         3'h0: output_divide_value = 4'hA;
         3'h1: output_divide_value = 4'h2;
         3'h2: output_divide_value = 4'h8;
         3'h3: output_divide_value = 4'h4;
         3'h4: output_divide_value = 4'h5;
         3'h5: output_divide_value = 4'h7;
         3'h6: output_divide_value = 4'h3;
         default: output_divide_value = 4'h6;
      endcase
   endfunction

   function automatic logic rising(input logic now, input logic was);
      rising = now & ~was;
   endfunction

   // ------------------------------------------------------------------
   // Reset release and pin synchronisers
   // ------------------------------------------------------------------
   logic rst_s1_r;
   logic rst_n;
   logic [4:0] pin_s1_r;
   logic [4:0] pin_s2_r;
   logic [4:0] pin_s3_r;

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         rst_s1_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n <= rst_s1_r;
      end
   end

   // Bit order: reference, power-down, load, data, serial clock.
   // The power-down copy resets high so outputs drive right after reset.
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_r <= PIN_RESET;
         pin_s2_r <= PIN_RESET;
         pin_s3_r <= PIN_RESET;
      end else begin
         pin_s1_r <= {REFERENCE_INPUT, POWER_DOWN_TRISTATE_N,
                      SER_LOAD, SER_DATA, SER_CLOCK};
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
      end
   end

   wire logic sclk_rise_w = rising(pin_s2_r[0], pin_s3_r[0]);
   wire logic data_w = pin_s2_r[1];
   wire logic load_w = pin_s2_r[2];
   wire logic load_rise_w = rising(pin_s2_r[2], pin_s3_r[2]);
   wire logic pd_w = ~pin_s2_r[3];
   wire logic ref_w = pin_s2_r[4];
   wire logic ref_rise_w = rising(pin_s2_r[4], pin_s3_r[4]);

   // ------------------------------------------------------------------
   // Shift register and setting latch
   // ------------------------------------------------------------------
   logic [SET_W-1:0] shift_r;
   logic [SET_W-1:0] latch_r;
   logic [4:0] count_r;
   logic shifted_r;

   // A pulse with the strobe already high copies straight through.
   wire logic load_now_w = load_rise_w | (load_w & shifted_r);
   wire logic [4:0] count_nxt = load_rise_w ? 5'h00 :
      (sclk_rise_w && count_r != 5'h1F) ? count_r + 5'h01 : count_r;

   // Not gated by power-down, and never cleared on leaving it.
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         shift_r <= '0;
         latch_r <= STARTUP_WORD;
         count_r <= '0;
         shifted_r <= 1'b0;
      end else begin
         if (sclk_rise_w) begin
            shift_r <= {shift_r[SET_W-2:0], data_w};
         end
         if (load_now_w) begin
            latch_r <= shift_r;
         end
         count_r <= count_nxt;
         shifted_r <= sclk_rise_w;
      end
   end

   // ------------------------------------------------------------------
   // Setting fields
   // ------------------------------------------------------------------
   wire logic [CRY_W-1:0] crystal_load_select =
      latch_r[CRY_LSB +: CRY_W];
   wire logic duty_trim = latch_r[TRIM_BIT];
   wire logic [SEC_W-1:0] secondary_source_select =
      latch_r[SEC_LSB +: SEC_W];
   wire logic [OSEL_W-1:0] output_divider_select =
      latch_r[OSEL_LSB +: OSEL_W];
   wire logic [FB_W-1:0] feedback_divider_word =
      latch_r[FB_LSB +: FB_W];
   wire logic [REFW_W-1:0] reference_divider_word =
      latch_r[REFW_LSB +: REFW_W];
   wire logic bypass_w = reference_divider_word == '0;

   // ------------------------------------------------------------------
   // Tuning word arithmetic
   // ------------------------------------------------------------------
   wire logic [31:0] fb_sum_w = 32'(feedback_divider_word) + 32'(FB_OFFSET);
   wire logic [31:0] ref_sum_w =
      32'(reference_divider_word) + 32'(REF_OFFSET);
   wire logic [31:0] num_w = 32'(fb_sum_w * 32'(REF_KHZ) * 32'd2);
   wire logic [31:0] den_w = 32'(ref_sum_w *
      32'(output_divide_value(output_divider_select)) * 32'(CLK_KHZ));

   logic div_start;
   logic div_busy;
   logic div_done;
   logic [31:0] div_quo;
   logic div_ovf;

   spcs_divider #(
      .NW(32),
      .DW(32),
      .FW(32)
   ) u_div (
      .clk(CLK),
      .rst_n(rst_n),
      .start(div_start),
      .num(num_w),
      .den(den_w),
      .busy(div_busy),
      .done(div_done),
      .quo(div_quo),
      .ovf(div_ovf)
   );

   // Above half the CLK rate the accumulator cannot follow, so clamp.
   wire logic clamp_w = div_ovf | (div_quo > TUNE_MAX);
   wire logic [31:0] quo_sat_w = clamp_w ? TUNE_MAX : div_quo;

   // ------------------------------------------------------------------
   // Tuning sequencer and glide
   // ------------------------------------------------------------------
   spcs_calc_e state_r;
   spcs_calc_e state_nxt;
   logic [SET_W-1:0] applied_r;
   logic [SET_W-1:0] applied_nxt;
   logic [31:0] target_r;
   logic [31:0] target_nxt;
   logic [31:0] tune_r;
   logic [31:0] tune_nxt;
   logic fresh_r;
   logic fresh_nxt;
   logic clamped_r;
   logic [7:0] tick_r;
   logic [31:0] ctrl_r;

   wire logic glide_en_w = ctrl_r[0];
   wire logic changed_w = fresh_r | (latch_r != applied_r);
   wire logic tick_hit_w = tick_r == 8'(GLIDE_TICK_CYCLES - 1);
   wire logic signed [32:0] diff_w = $signed({1'b0, target_r}) -
      $signed({1'b0, tune_r});
   wire logic signed [32:0] step_w = diff_w >>> GLIDE_SHIFT;
   wire logic [31:0] glide_next_w = (step_w == '0) ? target_r :
      tune_r + step_w[31:0];

   always_comb begin
      state_nxt = state_r;
      applied_nxt = applied_r;
      target_nxt = target_r;
      tune_nxt = tune_r;
      fresh_nxt = fresh_r;
      div_start = 1'b0;
      case (state_r)
         CALC_IDLE: begin
            if (changed_w && !pd_w) begin
               div_start = 1'b1;
               applied_nxt = latch_r;
               state_nxt = CALC_RUN;
            end
         end
         CALC_RUN: begin
            if (div_done) begin
               target_nxt = quo_sat_w;
               fresh_nxt = 1'b0;
               if (fresh_r || !glide_en_w) begin
                  tune_nxt = quo_sat_w;
                  state_nxt = CALC_IDLE;
               end else begin
                  state_nxt = CALC_GLIDE;
               end
            end
         end
         CALC_GLIDE: begin
            if (changed_w && !pd_w) begin
               div_start = 1'b1;
               applied_nxt = latch_r;
               state_nxt = CALC_RUN;
            end else if (!pd_w && tick_hit_w) begin
               tune_nxt = glide_next_w;
               if (glide_next_w == target_r) begin
                  state_nxt = CALC_IDLE;
               end
            end
         end
         default: state_nxt = CALC_IDLE;
      endcase
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= CALC_IDLE;
         applied_r <= '0;
         target_r <= '0;
         tune_r <= '0;
         fresh_r <= 1'b1;
         clamped_r <= 1'b0;
         tick_r <= '0;
      end else begin
         state_r <= state_nxt;
         applied_r <= applied_nxt;
         target_r <= target_nxt;
         tune_r <= tune_nxt;
         fresh_r <= fresh_nxt;
         if (div_done) begin
            clamped_r <= clamp_w;
         end
         tick_r <= tick_hit_w ? 8'h00 : tick_r + 8'h01;
      end
   end

   // ------------------------------------------------------------------
   // Oscillator and output routing
   // ------------------------------------------------------------------
   logic [31:0] acc_r;
   logic acc_msb_d_r;
   logic prim_half_r;
   logic ref_half_r;
   logic prim_r;
   logic sec_r;
   logic oe_n_r;

   // The synthesis path stops in power-down and in bypass.
   wire logic osc_run_w = !pd_w && !bypass_w;
   wire logic prim_src_w = bypass_w ? ref_w : acc_r[31];
   wire logic sec_sel_w =
      (secondary_source_select == SEC_REF) ? ref_w :
      (secondary_source_select == SEC_REF_HALF) ? ref_half_r :
      (secondary_source_select == SEC_PRIM_HALF) ? prim_half_r :
      1'b0;
   wire logic sec_src_w = bypass_w ? ref_w : sec_sel_w;

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         acc_r <= '0;
         acc_msb_d_r <= 1'b0;
         prim_half_r <= 1'b0;
         ref_half_r <= 1'b0;
         prim_r <= 1'b0;
         sec_r <= 1'b0;
         oe_n_r <= 1'b0;
      end else begin
         if (osc_run_w) begin
            acc_r <= acc_r + tune_r;
         end
         acc_msb_d_r <= acc_r[31];
         if (rising(acc_r[31], acc_msb_d_r)) begin
            prim_half_r <= ~prim_half_r;
         end
         if (ref_rise_w) begin
            ref_half_r <= ~ref_half_r;
         end
         prim_r <= pd_w ? 1'b0 : prim_src_w;
         sec_r <= pd_w ? 1'b0 : sec_src_w;
         oe_n_r <= pd_w;
      end
   end

   assign PRIMARY_OUT_CLOCK = prim_r;
   assign SECONDARY_OUT_CLOCK = sec_r;
   assign PRIMARY_OUT_OE_N = oe_n_r;
   assign SECONDARY_OUT_OE_N = oe_n_r;

   // ------------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------------
   logic [31:0] prdata_r;
   logic pslverr_r;

   wire logic setup_w = PSEL & ~PENABLE;
   wire logic access_w = PSEL & PENABLE;
   wire logic hit_set_w = PADDR == ADDR_SETTING;
   wire logic hit_shift_w = PADDR == ADDR_SHIFT;
   wire logic hit_stat_w = PADDR == ADDR_STATUS;
   wire logic hit_tune_w = PADDR == ADDR_TUNE;
   wire logic hit_ctrl_w = PADDR == ADDR_CTRL;
   wire logic mapped_w = hit_set_w | hit_shift_w | hit_stat_w |
      hit_tune_w | hit_ctrl_w;
   wire logic [31:0] status_w = {25'h000_0000, crystal_load_select,
      duty_trim, clamped_r, pd_w, state_r != CALC_IDLE, bypass_w};
   wire logic [31:0] rdata_w =
      hit_set_w ? {8'h00, latch_r} :
      hit_shift_w ? {3'h0, count_r, shift_r} :
      hit_stat_w ? status_w :
      hit_tune_w ? tune_r :
      hit_ctrl_w ? ctrl_r :
      32'h0000_0000;

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         prdata_r <= '0;
         pslverr_r <= 1'b0;
         ctrl_r <= CTRL_RESET;
      end else begin
         if (setup_w) begin
            prdata_r <= PWRITE ? 32'h0000_0000 : rdata_w;
            pslverr_r <= ~mapped_w;
         end
         if (access_w && PWRITE && hit_ctrl_w) begin
            ctrl_r <= {31'h0000_0000, PWDATA[0]};
         end
      end
   end

   assign PRDATA = prdata_r;
   assign PREADY = 1'b1;
   assign PSLVERR = pslverr_r;

endmodule

/* tb/spcs_top_asserts.sv */
// Purpose: Port-level checks of the clock synthesizer top.
// Assumes: Setting and status reads come after the latch has settled.
// Notes: Reference checks wait until the pin has rested a few cycles.
`timescale 1ns/1ps
module spcs_top_chk (
   // System
   input wire logic CLK,
   input wire logic NRST,
   // APB
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [spcs_pkg::ADDR_W-1:0] PADDR,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   // Pins
   input wire logic SER_LOAD,
   input wire logic REFERENCE_INPUT,
   input wire logic POWER_DOWN_TRISTATE_N,
   input wire logic PRIMARY_OUT_CLOCK,
   input wire logic PRIMARY_OUT_OE_N,
   input wire logic SECONDARY_OUT_CLOCK,
   input wire logic SECONDARY_OUT_OE_N
);
   import spcs_pkg::*;
   // -----------------------------------------------------------------
   // Helper logic
   // -----------------------------------------------------------------
   logic ref_d_r, have_set_r;
   logic [4:0] ref_cnt_r, load_cnt_r;
   logic [23:0] last_set_r;
   wire rd_acc = PSEL && PENABLE && !PWRITE;
   wire set_rd = rd_acc && (PADDR == ADDR_SETTING);
   wire sta_rd = rd_acc && (PADDR == ADDR_STATUS);
   wire mapped = PADDR inside {ADDR_SETTING, ADDR_SHIFT, ADDR_STATUS,
      ADDR_TUNE, ADDR_CTRL};
   // The resynchroniser lags the pin, so only a rested pin is compared.
   wire ref_quiet = (ref_cnt_r > 5'd6) && (REFERENCE_INPUT == ref_d_r);
   wire load_old = (load_cnt_r > 5'd1);
   wire [4:0] ref_cnt_nxt = (REFERENCE_INPUT != ref_d_r) ? 5'd0 :
      (ref_cnt_r == 5'd31) ? ref_cnt_r : ref_cnt_r + 5'd1;
   wire [4:0] load_cnt_nxt = SER_LOAD ? 5'd0 :
      ((&load_cnt_r) ? load_cnt_r : load_cnt_r + 5'd1);
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         ref_d_r <= 1'b0;
         ref_cnt_r <= '0;
         load_cnt_r <= '0;
         have_set_r <= 1'b0;
         last_set_r <= '0;
      end else begin
         ref_d_r <= REFERENCE_INPUT;
         ref_cnt_r <= ref_cnt_nxt;
         load_cnt_r <= load_cnt_nxt;
         have_set_r <= load_old && (have_set_r || set_rd);
         if (set_rd && load_old) begin
            last_set_r <= PRDATA[23:0];
         end
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!NRST);
   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   ready_high_a: assert property (PREADY)
      else $error("ready dropped");
   err_decode_a: assert property (PSEL && PENABLE |-> PSLVERR == !mapped)
      else $error("error response does not match the address map");
   pd_float_a: assert property (
      !POWER_DOWN_TRISTATE_N [*6] |->
      PRIMARY_OUT_OE_N && SECONDARY_OUT_OE_N)
      else $error("outputs driven during power-down");
   pd_quiet_a: assert property (
      !POWER_DOWN_TRISTATE_N [*6] |->
      !PRIMARY_OUT_CLOCK && !SECONDARY_OUT_CLOCK)
      else $error("clock toggles during power-down");
   pd_leave_a: assert property (
      $rose(POWER_DOWN_TRISTATE_N) |->
      ##[1:6] !PRIMARY_OUT_OE_N && !SECONDARY_OUT_OE_N)
      else $error("outputs not driven after power-up");
   sec_low_a: assert property (
      set_rd && PRDATA[20:19] == SEC_LOW && PRDATA[6:0] != 7'h0 |->
      !SECONDARY_OUT_CLOCK)
      else $error("secondary not held low");
   sec_ref_a: assert property (
      POWER_DOWN_TRISTATE_N [*8] ##0 (set_rd && ref_quiet &&
      PRDATA[20:19] == SEC_REF) |-> SECONDARY_OUT_CLOCK == REFERENCE_INPUT)
      else $error("secondary does not follow reference");
   bypass_ref_a: assert property (
      POWER_DOWN_TRISTATE_N [*8] ##0 (sta_rd && PRDATA[0] && ref_quiet)
      |-> PRIMARY_OUT_CLOCK == REFERENCE_INPUT &&
      SECONDARY_OUT_CLOCK == REFERENCE_INPUT)
      else $error("bypass outputs differ from reference");
   latch_kept_a: assert property (
      set_rd && load_old && have_set_r |-> PRDATA[23:0] == last_set_r)
      else $error("setting changed without a load");
endmodule

bind spcs_top spcs_top_chk u_chk (.CLK, .NRST, .PSEL, .PENABLE, .PWRITE,
   .PADDR, .PRDATA, .PREADY, .PSLVERR, .SER_LOAD, .REFERENCE_INPUT,
   .POWER_DOWN_TRISTATE_N, .PRIMARY_OUT_CLOCK, .PRIMARY_OUT_OE_N,
   .SECONDARY_OUT_CLOCK, .SECONDARY_OUT_OE_N);

/* tb/spcs_host.sv */
// Purpose: Host model that programs the setting word serially.
// Assumes: The serial clock stands low between words.
// Notes: Data flips after each word so a stale bit is never reused.
`timescale 1ns/1ps
module spcs_host (
   // Serial programming pins
   output logic ser_clock,
   output logic ser_data,
   output logic ser_load
);
   initial begin
      ser_clock = 1'b0;
      ser_data = 1'b0;
      ser_load = 1'b0;
   end
   task automatic send(input logic [23:0] w);
      int i;
      #13;
      for (i = 23; i >= 0; i--) begin
         ser_data = w[i];
         #100 ser_clock = 1'b1;
         #100 ser_clock = 1'b0;
      end
      ser_data = ~w[0];
      #100 ser_load = 1'b1;
      #100 ser_load = 1'b0;
   endtask
endmodule

/* tb/spcs_top_tb.sv */
// Purpose: Self-checking bench for the serial clock synthesizer.
// Assumes: Reference pin runs at 1 MHz; REF_KHZ gives the nominal rate.
// Notes: Tuning words get slack for the divider's rounding.
`timescale 1ns/1ps
module spcs_top_tb;
   import spcs_pkg::*;
   localparam int RK = 10_000;
   localparam int DIVS [8] = '{10, 2, 8, 4, 5, 7, 3, 6};
   localparam logic [31:0] ALL = 32'hffff_ffff;
   typedef struct {logic [31:0] e; logic [31:0] m; logic [31:0] t;}
      spcs_note_s;
   logic CLK = 0, NRST = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
   logic [7:0] PADDR = '0;
   logic [31:0] PWDATA = '0;
   logic [31:0] PRDATA;
   logic PREADY, PSLVERR, SER_CLOCK, SER_DATA, SER_LOAD;
   logic REFERENCE_INPUT = 0, POWER_DOWN_TRISTATE_N = 1;
   logic PRIMARY_OUT_CLOCK, PRIMARY_OUT_OE_N;
   logic SECONDARY_OUT_CLOCK, SECONDARY_OUT_OE_N;
   spcs_note_s q[$];
   int error_cnt = 0, n_tests = 0, cyc = 0;
   int seed = 32'h4bcc_f24e;
   always #12.5 CLK = ~CLK;
   always #500 REFERENCE_INPUT = ~REFERENCE_INPUT;
   spcs_top #(.REF_KHZ(RK)) uut (.CLK, .NRST, .PSEL, .PENABLE, .PWRITE,
      .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .SER_CLOCK, .SER_DATA,
      .SER_LOAD, .REFERENCE_INPUT, .POWER_DOWN_TRISTATE_N,
      .PRIMARY_OUT_CLOCK, .PRIMARY_OUT_OE_N, .SECONDARY_OUT_CLOCK,
      .SECONDARY_OUT_OE_N);
   spcs_host hm (.ser_clock(SER_CLOCK), .ser_data(SER_DATA),
      .ser_load(SER_LOAD));
   // -----------------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------------
   task automatic final_report();
      $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic cmp(input logic [31:0] g, input spcs_note_s n);
      logic [31:0] d;
      logic bad;
      d = (g > n.e) ? g - n.e : n.e - g;
      bad = (n.t == 0) ? ((g & n.m) !== n.e) : ($isunknown(g) || d > n.t);
      n_tests++;
      if (bad !== 1'b0) begin
         error_cnt++;
         $display("[ERR] t=%0t got %h exp %h", $time, g, n.e);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] r);
      @(posedge CLK);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      @(posedge CLK);
      while (PREADY !== 1'b1) @(posedge CLK);
      r = PRDATA;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
         input logic [31:0] m, input logic [31:0] t);
      logic [31:0] r;
      q.push_back('{e, m, t});
      apb(1'b0, a, 32'h0, r);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask
   function automatic logic [31:0] tune_of(input logic [23:0] w);
      logic [63:0] num;
      logic [63:0] qv;
      num = 64'(RK) * 2 * (64'(w[15:7]) + 8) << 32;
      qv = num / (64'(w[6:0] + 2) * DIVS[w[18:16]] * CLK_KHZ);
      return (qv > 64'(TUNE_MAX)) ? TUNE_MAX : qv[31:0];
   endfunction
   // Polls with empty notes, so only the final read is judged.
   task automatic chk_tune(input logic [23:0] w, input int lim);
      logic [31:0] e;
      logic [31:0] r;
      int k;
      e = tune_of(w);
      for (k = 0; k < lim; k++) begin
         q.push_back('{32'h0, 32'h0, 32'h0});
         apb(1'b0, ADDR_TUNE, 32'h0, r);
         if (r >= e - (e >> 8) - 2 && r <= e + (e >> 8) + 2) break;
      end
      rd(ADDR_TUNE, e, ALL, (e >> 8) + 2);
   endtask
   // -----------------------------------------------------------------
   // Monitor, watchdog and scenarios
   // -----------------------------------------------------------------
   always @(posedge CLK) begin
      if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE && q.size() > 0)
      begin
         if (q[0].m !== 32'h0) begin
            cmp(PRDATA, q[0]);
         end
         void'(q.pop_front());
      end
   end
   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (cyc == 90_000) begin
         error_cnt++;
         final_report();
      end
   end
   initial begin
      logic [23:0] w;
      int i, t0, lo, hi, rw;
      repeat (12) @(posedge CLK);
      NRST <= 1'b1;
      repeat (3) @(posedge CLK);
      rd(ADDR_CTRL, CTRL_RESET, ALL, 0);
      rd(8'h14, 32'h0, ALL, 0);
      wr(ADDR_SETTING, ALL);
      rd(ADDR_SETTING, 32'(STARTUP_DEFINED), ALL, 0);
      chk_tune(STARTUP_DEFINED, 200);
      wr(ADDR_CTRL, 32'h0);
      rd(ADDR_CTRL, 32'h0, ALL, 0);
      for (i = 0; i < 8; i++) begin
         rw = 1 + ($unsigned($random(seed)) % 46);
         lo = 4 * (rw + 2);
         hi = (18 * (rw + 2) < 520) ? 18 * (rw + 2) - 1 : 519;
         lo = lo + ($unsigned($random(seed)) % (hi - lo + 1)) - 8;
         w = {3'b001, 2'(i), 3'(i), 9'(lo), 7'(rw)};
         hm.send(w);
         chk_tune(w, 200);
         rd(ADDR_SETTING, 32'(w), ALL, 0);
         rd(ADDR_STATUS, 32'h10, 32'h75, 0);
      end
      hm.send({3'b001, SEC_LOW, 3'b011, 9'd40, 7'd0});
      repeat (3) rd(ADDR_STATUS, 32'h11, 32'h75, 0);
      w = {3'b001, SEC_REF_HALF, 3'b010, 9'd40, 7'd10};
      POWER_DOWN_TRISTATE_N <= 1'b0;
      repeat (8) @(posedge CLK);
      cmp({30'h0, PRIMARY_OUT_OE_N, SECONDARY_OUT_OE_N}, '{3, ALL, 0});
      hm.send(w);
      rd(ADDR_SETTING, 32'(w), ALL, 0);
      rd(ADDR_STATUS, 32'h14, 32'h75, 0);
      POWER_DOWN_TRISTATE_N <= 1'b1;
      repeat (8) @(posedge CLK);
      cmp({30'h0, PRIMARY_OUT_OE_N, SECONDARY_OUT_OE_N}, '{0, ALL, 0});
      rd(ADDR_SETTING, 32'(w), ALL, 0);
      chk_tune(w, 200);
      wr(ADDR_CTRL, CTRL_RESET);
      w = {3'b001, SEC_PRIM_HALF, 3'b010, 9'd34, 7'd10};
      t0 = cyc;
      hm.send(w);
      chk_tune(w, 20000);
      cmp({31'h0, (cyc - t0) > 1000}, '{1, ALL, 0});
      final_report();
   end
endmodule
